//--- design/cmbs_pkg.sv
package cmbs_pkg;
  // Byte positions inside a 16-byte buffer slot
  localparam logic [3:0] SLOT_ID0   = 4'h0;
  localparam logic [3:0] SLOT_ID1   = 4'h1;
  localparam logic [3:0] SLOT_ID2   = 4'h2;
  localparam logic [3:0] SLOT_ID3   = 4'h3;
  localparam logic [3:0] SLOT_DATA0 = 4'h4;
  localparam logic [3:0] SLOT_DATA7 = 4'hB;
  localparam logic [3:0] SLOT_LEN   = 4'hC;
  localparam logic [3:0] SLOT_PRIO  = 4'hD;
  localparam logic [3:0] SLOT_TSH   = 4'hE;
  localparam logic [3:0] SLOT_TSL   = 4'hF;
  localparam int         SLOT_BYTES = 16;
  localparam int         MSG_BYTES  = 13;
  // Extension flag position in identifier byte 1
  localparam int         IDE_BIT    = 3;

  // APB byte map, one word per register
  localparam logic [1:0] REG_RX_WIN = 2'h0; // 0x000-0x03C receive slot
  localparam logic [1:0] REG_TX_WIN = 2'h1; // 0x040-0x07C selected transmit slot
  localparam logic [1:0] REG_FILT   = 2'h2; // 0x080-0x08C mask, 0x090-0x09C code
  localparam logic [1:0] REG_MISC   = 2'h3;
  localparam logic [3:0] REG_STATUS = 4'h0; // 0x0C0
  localparam int         ADDR_W     = 12;

  // Reset values
  localparam logic [7:0] PRIO_RST   = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] CODE_RST   = 8'h00;

  typedef struct packed {
    logic [3:0][7:0] ident;
    logic [7:0][7:0] data;
    logic [3:0]      len;
  } cmbs_msg_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } cmbs_apb_req_t;
endpackage

//--- design/cmbs_store.sv
`timescale 1ns/1ps
// What this block does
// - Cleared mask bit demands acceptance code bit equal received identifier bit.
// - Set mask bit makes that acceptance code bit don't-care.
// - Mask registers readable always, writable only with init request and ack.
// - Transmit and receive buffers share one 16-byte slot layout.
// - Sample 16-bit timer into last two slot bytes after each success.
// - Time stamp captured only while timestamp enable is set.
// - Time stamp bytes are read-only; processor writes ignored.
// - Priority byte exists only in transmit buffers.
// - Reset clears transmit priorities; other buffer bits stay unknown.
// - Reserved and unused buffer bits read undefined; here receive priority byte and receive length high nibble read zero.
// - Bytes 0-3 identifier, 4-11 data, 12 length code in low nibble.
// - Extended identifier mapping keeps SRR and extension flag in byte 1.
// - Standard mapping uses bytes 0-1, extension flag zero in bit 3.
// - Transmit buffer accessible only when empty and selected.
// - Receive buffer readable only while full; writes ignored.
// - Extension flag shows received format; in transmit selects format.
// - Messages land in background buffer; rejected ones are silently overwritten.
// - Standard identifiers use first two filter pairs, extended all four.
module cmbs_store
  import cmbs_pkg::*;
#(
  parameter int NTX = 3
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [ADDR_W-1:0]       paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic      [31:0]             prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  input  wire logic                    init_request_i,
  input  wire logic                    init_ack_i,
  input  wire logic                    timestamp_enable_i,
  input  wire logic [NTX-1:0]          tx_buffer_empty_flag_i,
  input  wire logic [NTX-1:0]          tx_buffer_select_i,
  input  wire logic                    rx_full_flag_i,
  input  wire logic [15:0]             timer_i,
  input  wire logic                    rx_valid_i,
  input  wire cmbs_msg_t               rx_msg_i,
  input  wire logic                    tx_done_i,
  input  wire logic [$clog2(NTX)-1:0]  tx_done_idx_i,
  input  wire logic [$clog2(NTX)-1:0]  tx_fetch_idx_i,
  output cmbs_msg_t                    tx_msg_o,
  output logic      [NTX-1:0][7:0]     tx_prio_o,
  output logic                         rx_accept_o
);
  localparam int IW = $clog2(NTX);

  // Buffer storage is RAM-like: no reset except priorities
  logic [7:0]       tx_mem [NTX][SLOT_BYTES];
  logic [7:0]       rx_fg  [SLOT_BYTES];
  cmbs_msg_t        rx_bg_q;
  logic [15:0]      rx_bg_ts_q;
  logic             rx_chk_q;
  logic [NTX-1:0][7:0] prio_q;
  logic [3:0][7:0]  mask_q;
  logic [3:0][7:0]  code_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      prdata_q;
  cmbs_msg_t        tx_msg_q;
  logic             rx_accept_q;

  // Address decode
  wire logic [1:0]  region    = paddr_i[7:6];
  wire logic [3:0]  slot_byte = paddr_i[5:2];
  wire logic        hi_zero   = (paddr_i[ADDR_W-1:8] == '0);
  wire logic        misc_hit  = (region == REG_MISC) && (slot_byte == REG_STATUS);
  wire logic        mapped    = hi_zero && (paddr_i[1:0] == 2'b00) &&
                                ((region != REG_MISC) || misc_hit);
  wire logic        init_mode = init_request_i & init_ack_i;
  wire logic        acc_ph    = psel_i & penable_i & ~pready_q;
  wire logic        wr_go     = psel_i & penable_i & pready_q & pwrite_i & mapped;

  // Selected transmit buffer, valid only if exactly one select bit is set
  logic [IW-1:0] tx_sel;
  logic          tx_one;
  always_comb begin
    tx_sel = '0;
    tx_one = 1'b0;
    for (int i = 0; i < NTX; i++) begin
      if (tx_buffer_select_i[i]) begin
        tx_sel = IW'(i);
      end
    end
    tx_one = $onehot(tx_buffer_select_i);
  end
  wire logic tx_ok = tx_one && ((tx_buffer_empty_flag_i & tx_buffer_select_i) != '0);

  // Write permissions
  wire logic tx_wr   = wr_go && (region == REG_TX_WIN) && tx_ok &&
                       (slot_byte != SLOT_TSH) && (slot_byte != SLOT_TSL);
  wire logic prio_wr = tx_wr && (slot_byte == SLOT_PRIO);
  wire logic filt_wr = wr_go && (region == REG_FILT) && init_mode;

  // Acceptance filter on the background buffer
  wire logic        rx_ext = rx_bg_q.ident[3-1][IDE_BIT];
  logic [3:0] pair_ok;
  for (genvar g = 0; g < 4; g++) begin : g_filt
    // Identifier byte 0 sits in the top lane of the packed ident field
    wire logic [7:0] id_b = rx_bg_q.ident[3-g];
    wire logic       used = (g < 2) || rx_ext;
    assign pair_ok[g] = !used || (((code_q[g] ^ id_b) & ~mask_q[g]) == 8'h00);
  end
  wire logic rx_hit = &pair_ok;

  // Read mux, one word per slot byte, narrow data in the low bits
  logic [7:0] tx_rd;
  logic [7:0] rx_rd;
  logic [7:0] rd_byte;
  always_comb begin
    tx_rd   = (slot_byte == SLOT_PRIO) ? prio_q[tx_sel] : tx_mem[tx_sel][slot_byte];
    rx_rd   = (slot_byte == SLOT_PRIO) ? 8'h00 : rx_fg[slot_byte];
    rd_byte = 8'h00;
    unique case (region)
      REG_RX_WIN: rd_byte = rx_full_flag_i ? rx_rd : 8'h00;
      REG_TX_WIN: rd_byte = tx_ok ? tx_rd : 8'h00;
      REG_FILT:   rd_byte = slot_byte[2] ? code_q[slot_byte[1:0]]
                                         : mask_q[slot_byte[1:0]];
      REG_MISC:   rd_byte = {5'h00, init_mode, rx_full_flag_i, tx_ok};
    endcase
  end

  // APB answer: one wait cycle, then pready with registered data
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc_ph;
      pslverr_q <= acc_ph & ~mapped;
      prdata_q  <= (acc_ph && mapped && !pwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Filter registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= {4{MASK_RST}};
      code_q <= {4{CODE_RST}};
    end else if (filt_wr && !slot_byte[3]) begin
      if (slot_byte[2]) begin
        code_q[slot_byte[1:0]] <= pwdata_i[7:0];
      end else begin
        mask_q[slot_byte[1:0]] <= pwdata_i[7:0];
      end
    end
  end

  // Priorities are the only buffer bytes with a reset value
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prio_q <= {NTX{PRIO_RST}};
    end else if (prio_wr) begin
      prio_q[tx_sel] <= pwdata_i[7:0];
    end
  end

  // Transmit slot storage; stamp bytes written only by the block
  always_ff @(posedge ref_clk_i) begin
    if (tx_wr && (slot_byte != SLOT_PRIO)) begin
      // Length byte stores all eight written bits; the engine fetch uses only its code nibble
      tx_mem[tx_sel][slot_byte] <= pwdata_i[7:0];
    end
    if (tx_done_i && timestamp_enable_i) begin
      tx_mem[tx_done_idx_i][SLOT_TSH] <= timer_i[15:8];
      tx_mem[tx_done_idx_i][SLOT_TSL] <= timer_i[7:0];
    end
  end

  // Background buffer takes every frame; a rejected one is simply overwritten
  always_ff @(posedge ref_clk_i) begin
    if (rx_valid_i) begin
      rx_bg_q    <= rx_msg_i;
      rx_bg_ts_q <= timer_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_chk_q    <= 1'b0;
      rx_accept_q <= 1'b0;
    end else begin
      rx_chk_q    <= rx_valid_i;
      rx_accept_q <= rx_chk_q & rx_hit;
    end
  end

  // Foreground receive slot, same layout as a transmit slot
  always_ff @(posedge ref_clk_i) begin
    if (rx_chk_q && rx_hit) begin
      for (int b = 0; b < 4; b++) begin
        rx_fg[b] <= rx_bg_q.ident[3-b];
      end
      for (int b = 0; b < 8; b++) begin
        rx_fg[4+b] <= rx_bg_q.data[7-b];
      end
      rx_fg[SLOT_LEN]  <= {4'h0, rx_bg_q.len};
      rx_fg[SLOT_PRIO] <= 8'h00;
      if (timestamp_enable_i) begin
        rx_fg[SLOT_TSH] <= rx_bg_ts_q[15:8];
        rx_fg[SLOT_TSL] <= rx_bg_ts_q[7:0];
      end
    end
  end

  // Engine fetch of a transmit buffer, one cycle latency
  cmbs_msg_t tx_fetch;
  always_comb begin
    tx_fetch = '0;
    for (int b = 0; b < 4; b++) begin
      tx_fetch.ident[3-b] = tx_mem[tx_fetch_idx_i][b];
    end
    for (int b = 0; b < 8; b++) begin
      tx_fetch.data[7-b] = tx_mem[tx_fetch_idx_i][4+b];
    end
    tx_fetch.len = tx_mem[tx_fetch_idx_i][SLOT_LEN][3:0];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_msg_q <= '0;
    end else begin
      tx_msg_q <= tx_fetch;
    end
  end

  assign prdata_o    = prdata_q;
  assign pready_o    = pready_q;
  assign pslverr_o   = pslverr_q;
  assign tx_msg_o    = tx_msg_q;
  assign tx_prio_o   = prio_q;
  assign rx_accept_o = rx_accept_q;
endmodule

//--- dv/cmbs_store_properties.sv
`timescale 1ns/1ps
module cmbs_store_properties
  import cmbs_pkg::*;
#(
  parameter int NTX = 3
) (
  input wire logic                ref_clk_i,
  input wire logic                rst_n_i,
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic                pwrite_i,
  input wire logic [ADDR_W-1:0]   paddr_i,
  input wire logic [31:0]         prdata_o,
  input wire logic                pready_o,
  input wire logic                pslverr_o,
  input wire logic [NTX-1:0]      tx_buffer_empty_flag_i,
  input wire logic [NTX-1:0]      tx_buffer_select_i,
  input wire logic                rx_full_flag_i,
  input wire logic                rx_valid_i,
  input wire logic [NTX-1:0][7:0] tx_prio_o,
  input wire logic                rx_accept_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic rd = pready_o && !pwrite_i;
  wire logic tx_ok = (tx_buffer_select_i & tx_buffer_empty_flag_i) != '0;
  a_one_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("ready not after one wait state");
  a_err_pair: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_err_unmapped: assert property (pready_o && paddr_i[11:8] != 4'h0 |-> pslverr_o)
    else $error("unmapped access without error");
  a_rx_blocked: assert property (rd && paddr_i[7:6] == 2'h0 && !rx_full_flag_i |-> prdata_o == 0)
    else $error("receive slot readable while not full");
  a_tx_blocked: assert property (rd && paddr_i[7:6] == 2'h1 && !tx_ok |-> prdata_o == 0)
    else $error("transmit slot readable while blocked");
  a_prio_reset: assert property ($rose(rst_n_i) |-> tx_prio_o == '0)
    else $error("priority not clear after reset");
  a_rx_no_prio: assert property (rd && paddr_i[7:0] == 8'h34 |-> prdata_o == 0)
    else $error("receive priority byte not zero");
  a_rx_len_nib: assert property (rd && paddr_i[7:0] == 8'h30 |-> prdata_o[31:4] == 0)
    else $error("receive length upper bits set");
  a_accept_lat: assert property (rx_accept_o |-> $past(rx_valid_i, 2) || $past(rx_valid_i, 3))
    else $error("accept without a frame");
endmodule
bind cmbs_store cmbs_store_properties #(.NTX(NTX)) i_props (.*);

//--- dv/cmbs_engine_model.sv
`timescale 1ns/1ps
module cmbs_engine_model
  import cmbs_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  output logic [15:0] timer_o,
  output logic        rx_valid_o,
  output cmbs_msg_t   rx_msg_o,
  output logic        tx_done_o,
  output logic [1:0]  tx_done_idx_o
);
  logic [15:0] stamp;
  initial begin
    rx_valid_o = 1'b0;
    rx_msg_o = '0;
    tx_done_o = 1'b0;
    tx_done_idx_o = 2'h0;
  end
  // Odd step so two captures never see the same stamp
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) timer_o <= 16'h0100;
    else timer_o <= timer_o + 16'h0007;
  task automatic send(input cmbs_msg_t m);
    rx_valid_o <= 1'b1;
    rx_msg_o <= m;
    @(posedge clk_i);
    stamp = timer_o;
    rx_valid_o <= 1'b0;
    rx_msg_o <= ~m;
  endtask
  task automatic done(input logic [1:0] idx);
    tx_done_o <= 1'b1;
    tx_done_idx_o <= idx;
    @(posedge clk_i);
    stamp = timer_o;
    tx_done_o <= 1'b0;
    tx_done_idx_o <= ~idx;
  endtask
endmodule

//--- dv/cmbs_store_tb.sv
`timescale 1ns/1ps
module cmbs_store_tb
  import cmbs_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic init_rq = 1'b0, init_ak = 1'b0, ts_en = 1'b0, rx_full = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, rx_valid, tx_done, rx_accept, e;
  logic [2:0] tx_empty = 3'h7, tx_sel = 3'h1;
  logic [1:0] tx_done_idx, tx_fetch = 2'h0;
  logic [15:0] timer, s;
  cmbs_msg_t rx_msg, tx_msg;
  logic [2:0][7:0] tx_prio;
  int mismatches = 0, checks = 0;
  always #20 clk = ~clk;
  cmbs_engine_model i_eng (.clk_i(clk), .rst_n_i(rst_n), .timer_o(timer), .rx_valid_o(rx_valid),
    .rx_msg_o(rx_msg), .tx_done_o(tx_done), .tx_done_idx_o(tx_done_idx));
  cmbs_store #(.NTX(3)) i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .init_request_i(init_rq),
    .init_ack_i(init_ak), .timestamp_enable_i(ts_en), .tx_buffer_empty_flag_i(tx_empty),
    .tx_buffer_select_i(tx_sel), .rx_full_flag_i(rx_full), .timer_i(timer),
    .rx_valid_i(rx_valid), .rx_msg_i(rx_msg), .tx_done_i(tx_done), .tx_done_idx_i(tx_done_idx),
    .tx_fetch_idx_i(tx_fetch), .tx_msg_o(tx_msg), .tx_prio_o(tx_prio), .rx_accept_o(rx_accept));
  task automatic chk(input logic [31:0] x, input logic [31:0] got);
    checks++;
    if (got !== x) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk({24'h0, x}, r);
  endtask
  // Frame with identifier bytes 0x12, b1, b2, 0x56; b1 sets substitute bit and extension flag
  task automatic rx(input logic [7:0] b1, input logic [7:0] b2, input logic ok);
    cmbs_msg_t m;
    logic seen;
    seen = 1'b0;
    m.ident = {8'h12, b1, b2, 8'h56};
    m.data = 64'h0123456789ABCDEF;
    m.len = 4'h8;
    i_eng.send(m);
    repeat (4) begin
      @(posedge clk);
      seen = seen | rx_accept;
    end
    chk({31'h0, ok}, {31'h0, seen});
  endtask
  task automatic t_regs();
    rchk(12'h074, 8'h00);
    chk(32'h0, 32'(tx_prio));
    apb(1'b0, 12'h100, 8'h00);
    chk(32'h1, {31'h0, e});
    init_rq <= 1'b1;
    apb(1'b1, 12'h080, 8'hFF);
    rchk(12'h080, 8'h00);
    init_ak <= 1'b1;
    apb(1'b1, 12'h090, 8'h12);
    apb(1'b1, 12'h094, 8'hBA);
    apb(1'b1, 12'h098, 8'h34);
    apb(1'b1, 12'h09C, 8'h56);
    rchk(12'h094, 8'hBA);
    $display("t_regs done");
  endtask
  task automatic t_rx();
    ts_en <= 1'b1;
    rx_full <= 1'b1;
    rx(8'hBA, 8'h34, 1'b1);
    rchk(12'h004, 8'hBA);
    rchk(12'h010, 8'h01);
    rchk(12'h030, 8'h08);
    rchk(12'h038, i_eng.stamp[15:8]);
    rchk(12'h03C, i_eng.stamp[7:0]);
    rx(8'hBA, 8'h35, 1'b0);
    rchk(12'h008, 8'h34);
    apb(1'b1, 12'h088, 8'h01);
    rx(8'hBA, 8'h35, 1'b1);
    apb(1'b1, 12'h084, 8'h0F);
    rx(8'hB0, 8'h00, 1'b1);
    rchk(12'h004, 8'hB0);
    apb(1'b1, 12'h010, 8'hEE);
    rchk(12'h010, 8'h01);
    rx_full <= 1'b0;
    rchk(12'h010, 8'h00);
    $display("t_rx done");
  endtask
  task automatic t_tx();
    apb(1'b1, 12'h040, 8'hA5);
    apb(1'b1, 12'h050, 8'h3C);
    apb(1'b1, 12'h070, 8'h08);
    apb(1'b1, 12'h074, 8'h07);
    rchk(12'h074, 8'h07);
    chk(32'h7, 32'(tx_prio[0]));
    chk(32'h000A53C8, {12'h000, tx_msg.ident[3], tx_msg.data[7], tx_msg.len});
    i_eng.done(2'h0);
    s = i_eng.stamp;
    rchk(12'h078, s[15:8]);
    ts_en <= 1'b0;
    i_eng.done(2'h0);
    rchk(12'h07C, s[7:0]);
    apb(1'b1, 12'h07C, ~s[7:0]);
    rchk(12'h07C, s[7:0]);
    tx_empty <= 3'h6;
    apb(1'b1, 12'h040, 8'h11);
    rchk(12'h040, 8'h00);
    tx_empty <= 3'h7;
    rchk(12'h040, 8'hA5);
    $display("t_tx done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_rx();
    t_tx();
    test_done();
  end
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule
